// ---- inc/ident_readback_consts.vh ----
// What this block does
// - Command AFh or address AF00h returns the one-byte continue checksum.
// - These read commands are answered in every power state, sleep included.
// - Power-on, software or hardware reset makes the checksum read 00h.
// - Command DAh or DA00h returns manufacturer byte, 00h until programmed.
// - Command DBh or DB00h returns module version byte from programmed store.
`ifndef IDENT_READBACK_CONSTS_VH
`define IDENT_READBACK_CONSTS_VH
`define CMD_CHECKSUM     8'hAF
`define CMD_FIRST_ID     8'hDA
`define CMD_SECOND_ID    8'hDB
`define CMD_THIRD_ID     8'hDC
`define ADDR_CHECKSUM    16'hAF00
`define ADDR_FIRST_ID    16'hDA00
`define ADDR_SECOND_ID   16'hDB00
`define ADDR_THIRD_ID    16'hDC00
`define LOW_MSB          7
`define LOW_LSB          0
`define HIGH_MSB         15
`define HIGH_LSB         8
`define BYTE_ZERO        8'h00
`define WORD_ZERO        16'h0000
`define HOST_WAIT_MS     300
`endif

// ---- design/ident_byte_store.v ----
`timescale 1ns/1ps
`include "ident_readback_consts.vh"
module ident_byte_store
#(
	parameter WIDTH = 8
)
(
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Programmed store side
	input  wire             programmed,
	input  wire [WIDTH-1:0] stored_value,
	// Value seen by the host
	output reg  [WIDTH-1:0] value
);
	// Unprogrammed store reads zero
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			value <= `BYTE_ZERO;
		else if (programmed)
			value <= stored_value;
		else
			value <= `BYTE_ZERO;
	end
endmodule // ident_byte_store

// ---- design/ident_readback.v ----
`timescale 1ns/1ps
`include "ident_readback_consts.vh"
module ident_readback
#(
	parameter DATA_WIDTH = 8,
	parameter ADDR_WIDTH = 16,
	parameter BUS_WIDTH  = 16
)
(
	// Clock and reset
	input  wire                  clk,
	input  wire                  rst,
	input  wire                  soft_reset,
	// Host read request
	input  wire                  read_req,
	input  wire                  serial_link,
	input  wire                  wide_bus,
	input  wire [ADDR_WIDTH-1:0] read_addr,
	// Checksum engine
	input  wire                  checksum_update,
	input  wire [DATA_WIDTH-1:0] checksum_in,
	// One-time-programmable store
	input  wire                  otp_programmed,
	input  wire [DATA_WIDTH-1:0] manufacturer_otp,
	input  wire [DATA_WIDTH-1:0] version_otp,
	input  wire [DATA_WIDTH-1:0] driver_otp,
	// Answer
	output reg                   read_valid,
	output reg                   read_hit,
	output reg  [BUS_WIDTH-1:0]  read_data
);
	// One-hot codes of the answered command
	localparam PICK_NONE     = 5'b00001;
	localparam PICK_CHECKSUM = 5'b00010;
	localparam PICK_FIRST    = 5'b00100;
	localparam PICK_SECOND   = 5'b01000;
	localparam PICK_THIRD    = 5'b10000;

	// Held checksum and stored identity bytes
	reg  [DATA_WIDTH-1:0] continue_checksum_value;
	wire [DATA_WIDTH-1:0] manufacturer_ident_value;
	wire [DATA_WIDTH-1:0] version_ident_value;
	wire [DATA_WIDTH-1:0] driver_ident_value;

	// Command decode
	wire [7:0]            code;
	wire                  addr_form_ok;
	wire                  match_checksum;
	wire                  match_first_id;
	wire                  match_second_id;
	wire                  match_third_id;
	reg  [4:0]            pick;
	reg  [DATA_WIDTH-1:0] sel;
	reg                   hit;

	// Next values of the answer flops
	reg                   next_read_valid;
	reg                   next_read_hit;
	reg  [BUS_WIDTH-1:0]  next_read_data;

	// Software reset outranks a same-cycle checksum update
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			continue_checksum_value <= `BYTE_ZERO;
		end
		else if (soft_reset)
		begin
			continue_checksum_value <= `BYTE_ZERO;
		end
		else if (checksum_update)
		begin
			continue_checksum_value <= checksum_in;
		end
	end

	ident_byte_store
	#(
		.WIDTH (DATA_WIDTH)
	)
	u_first
	(
		.clk          (clk),
		.rst          (rst),
		.programmed   (otp_programmed),
		.stored_value (manufacturer_otp),
		.value        (manufacturer_ident_value)
	);

	ident_byte_store
	#(
		.WIDTH (DATA_WIDTH)
	)
	u_second
	(
		.clk          (clk),
		.rst          (rst),
		.programmed   (otp_programmed),
		.stored_value (version_otp),
		.value        (version_ident_value)
	);

	ident_byte_store
	#(
		.WIDTH (DATA_WIDTH)
	)
	u_third
	(
		.clk          (clk),
		.rst          (rst),
		.programmed   (otp_programmed),
		.stored_value (driver_otp),
		.value        (driver_ident_value)
	);

	// Serial link sends the bare code; a bus address carries it in the high byte
	assign code = serial_link ? read_addr[`LOW_MSB:`LOW_LSB]
	                          : read_addr[`HIGH_MSB:`HIGH_LSB];

	// A bus address with a nonzero low byte names no readback command
	assign addr_form_ok    = serial_link | (read_addr[`LOW_MSB:`LOW_LSB] == `BYTE_ZERO);
	assign match_checksum  = addr_form_ok & (code == `CMD_CHECKSUM);
	assign match_first_id  = addr_form_ok & (code == `CMD_FIRST_ID);
	assign match_second_id = addr_form_ok & (code == `CMD_SECOND_ID);
	assign match_third_id  = addr_form_ok & (code == `CMD_THIRD_ID);

	// Priority is moot: the four codes are distinct
	always @*
	begin
		pick = PICK_NONE;
		if (match_checksum)
		begin
			pick = PICK_CHECKSUM;
		end
		else if (match_first_id)
		begin
			pick = PICK_FIRST;
		end
		else if (match_second_id)
		begin
			pick = PICK_SECOND;
		end
		else if (match_third_id)
		begin
			pick = PICK_THIRD;
		end
	end

	// No power-state input: answered in sleep too
	always @*
	begin
		sel = `BYTE_ZERO;
		hit = 1'b0;
		case (pick)
			PICK_CHECKSUM:
			begin
				sel = continue_checksum_value;
				hit = 1'b1;
			end
			PICK_FIRST:
			begin
				sel = manufacturer_ident_value;
				hit = 1'b1;
			end
			PICK_SECOND:
			begin
				sel = version_ident_value;
				hit = 1'b1;
			end
			PICK_THIRD:
			begin
				sel = driver_ident_value;
				hit = 1'b1;
			end
			default:
			begin
				sel = `BYTE_ZERO;
				hit = 1'b0;
			end
		endcase
	end

	// Answer formed here, then registered so every output is a flop
	always @*
	begin
		next_read_valid = read_req;
		next_read_hit   = read_req & hit;
		next_read_data  = read_data;
		if (read_req)
		begin
			next_read_data = {`BYTE_ZERO, sel};
		end
	end

	// Valid and hit stand for one cycle per request
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			read_valid <= 1'b0;
		end
		else
		begin
			read_valid <= next_read_valid;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			read_hit <= 1'b0;
		end
		else
		begin
			read_hit <= next_read_hit;
		end
	end

	// Data holds until the next request, so a slow host may fetch it late
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			read_data <= `WORD_ZERO;
		end
		else
		begin
			read_data <= next_read_data;
		end
	end
endmodule // ident_readback

// ---- bench/ident_readback_sva.sv ----
`timescale 1ns/1ps
module ident_readback_sva
(
	// Clock and reset
	input logic        clk,
	input logic        rst,
	// Host side
	input logic        read_req,
	input logic        serial_link,
	input logic [15:0] read_addr,
	// Checksum control
	input logic        soft_reset,
	input logic        checksum_update,
	// Answer
	input logic        read_valid,
	input logic        read_hit,
	input logic [15:0] read_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [7:0] c = serial_link ? read_addr[7:0] : read_addr[15:8];
	wire form = serial_link || !read_addr[7:0];
	wire q = form && c inside {8'hAF, 8'hDA, 8'hDB, 8'hDC};
	wire ccs = form && c == 8'hAF;
	AST_ANSWER: assert property (read_req |=> read_valid) else $error("late");
	AST_QUIET: assert property (!read_req |=> !read_valid) else $error("extra");
	AST_UPPER: assert property (read_valid |-> !read_data[15:8]) else $error("upper");
	AST_HIT: assert property (read_req && q |=> read_hit) else $error("hit");
	AST_MISS: assert property (read_req && !q |=> !read_hit) else $error("miss");
	AST_CLEAR: assert property (
		soft_reset ##1 !checksum_update ##1 (read_req && ccs) |=> read_data == 16'h0000)
		else $error("clear");
	AST_HOLD: assert property (!read_req |=> $stable(read_data)) else $error("hold");
endmodule // ident_readback_sva
bind ident_readback ident_readback_sva sva (.*);

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
module host_model (
	input logic clk, read_valid, read_hit,
	input logic [15:0] read_data,
	output logic read_req = 0, serial_link = 0,
	output logic [15:0] read_addr = 0
);
	task rd(input logic s, input logic [15:0] a, output logic [17:0] d);
		@(posedge clk);
		{read_req, serial_link, read_addr} <= {1'b1, s, a};
		@(posedge clk);
		{read_req, read_addr} <= {1'b0, ~a};
		#1 d = {read_valid, read_hit, read_data};
	endtask
endmodule // host_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, soft_reset = 0, checksum_update = 0, otp_programmed = 0;
	logic read_valid, read_hit, read_req, serial_link;
	logic [15:0] read_addr, read_data;
	logic [17:0] d, x;
	logic [7:0] checksum_in = 8'h5A, id [3] = '{8'hA5, 8'h3C, 8'hC3};
	int n_mismatch = 0, checks = 0, cyc = 0;
	ident_readback dut (.*, .wide_bus(1'b1), .manufacturer_otp(id[0]), .version_otp(id[1]),
		.driver_otp(id[2]));
	host_model host (.*);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (++cyc > 900) begin n_mismatch++; close_out(); end
	task close_out;
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic s, h, input logic [15:0] a, input logic [7:0] e);
		host.rd(s, a, d);
		x = {1'b1, h, 8'h00, e};
		checks++;
		if (d !== x) begin n_mismatch++; $display("[FAIL] %0t %h %h", $time, d, x); end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		chk(0, 1, 16'hAF00, 0);
		chk(1, 1, 16'h00DC, 0);
		// Engine result is taken as settled; the long host wait is not run
		@(posedge clk) {otp_programmed, checksum_update} <= 2'b11;
		@(posedge clk) checksum_update <= 0;
		chk(1, 1, 16'h00AF, 8'h5A);
		@(posedge clk) {soft_reset, checksum_update} <= 2'b11;
		@(posedge clk) {soft_reset, checksum_update} <= 2'b00;
		chk(0, 1, 16'hAF00, 0);
		for (int i = 0; i < 6; i++)
			chk(i[0], 1, 16'hDA00 + i / 2 * 256 >> 8 * i[0], id[i / 2]);
		chk(0, 0, 16'hDA01, 0);
		close_out();
	end
endmodule // testbench
